//--- hw/pmfc_byte_mux.sv
// Purpose: Picks the byte of a 12-bit sample to present at a data address
// Assumes: Sample occupies two consecutive addresses, first at even offset
// Notes: Registered read data
`timescale 1ns/10ps
module pmfc_byte_mux
  import pmfc_pkg::*;
#(
  parameter int SAMPLE_W = PMFC_SAMPLE_W
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [SAMPLE_W-1:0] sample,
  input wire logic upper_addr,
  input wire logic formatted,
  input wire logic big_endian,
  input wire logic fast_read,
  output logic [7:0] byte_r
);
  logic [15:0] right_just;
  logic [15:0] left_just;
  logic [7:0] msb_byte;
  logic [7:0] byte_nxt;

  assign right_just = {{(16 - SAMPLE_W){1'b0}}, sample};
  assign left_just = {sample, {(16 - SAMPLE_W){1'b0}}};
  assign msb_byte = sample[SAMPLE_W-1 -: 8];
  assign byte_nxt = !formatted ? (upper_addr ? right_just[15:8] : right_just[7:0]) :
    fast_read ? msb_byte :
    big_endian ? (upper_addr ? left_just[7:0] : left_just[15:8]) :
    (upper_addr ? right_just[15:8] : right_just[7:0]);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      byte_r <= 8'h00;
    end else begin
      byte_r <= byte_nxt;
    end
  end
endmodule // pmfc_byte_mux

//--- hw/pmfc_config.sv
// Purpose: Power mode and output format configuration register with its decode
// Assumes: Internal register port, one access per cycle, synchronous reset
// Notes: Sampling engine, rate tables and idle timers sit outside
`timescale 1ns/10ps
// Operation
// - Wake 00: low power, upper nibble rate
// - Wake 01: high performance, upper nibble rate
// - Wake 1x: flexible, upper nibble decimation, idle
// - Sleep 00/01: low/high perf, lower nibble rate
// - Sleep 1x: flexible, lower nibble decimation, idle
// - Order 0: low byte first, right-justified
// - Order 1: high byte first, left-justified
// - Order applies only to output sample data
// - Temperature in auto-increment only when enabled
// - Fast read: MSB only, at lower address
// - Fast burst skips each axis and buffer sample's high address; magnitude steps by one
module pmfc_config
  import pmfc_pkg::*;
#(
  parameter int SAMPLE_W = PMFC_SAMPLE_W,
  parameter int IDLE_W = 12
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic [7:0] rate_decimation_config,
  input wire logic [IDLE_W-1:0] wake_idle_time,
  input wire logic [IDLE_W-1:0] sleep_idle_time,
  input wire logic sleep_state,
  input wire logic [SAMPLE_W-1:0] data_sample,
  input wire logic [7:0] data_rdata,
  input wire logic burst_active,
  input wire logic [7:0] burst_addr,
  output logic [7:0] burst_next_addr,
  output logic [7:0] out_rdata,
  output pmfc_mode_type wake_mode,
  output pmfc_mode_type sleep_mode,
  output pmfc_mode_type active_mode,
  output logic [3:0] wake_rate_code,
  output logic [3:0] wake_decimation_code,
  output logic [3:0] sleep_rate_code,
  output logic [3:0] sleep_decimation_code,
  output logic [3:0] active_code,
  output logic active_code_is_rate,
  output logic [IDLE_W-1:0] active_idle_time,
  output logic output_byte_order_sel,
  output logic temperature_autoinc_incl,
  output logic msb_only_read_sel
);
  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] power_mode_and_format_config_r;
  logic [7:0] power_mode_and_format_config_nxt;
  logic cfg_sel;
  logic [1:0] wake_power_mode_sel;
  logic [1:0] sleep_power_mode_sel;
  logic sample_data_r;

  assign cfg_sel = (reg_addr == PMFC_CFG_ADDR);
  assign reg_hit = cfg_sel & (reg_wr | reg_rd);
  assign power_mode_and_format_config_nxt = (reg_wr && cfg_sel) ? reg_wdata :
    power_mode_and_format_config_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      power_mode_and_format_config_r <= PMFC_CFG_RST;
    end else begin
      power_mode_and_format_config_r <= power_mode_and_format_config_nxt;
    end
  end

  // Reserved bit stored and read back; nothing looks at it
  assign reg_rdata = power_mode_and_format_config_r;

  // ****************************************
  // Field decode
  // ****************************************
  assign wake_power_mode_sel =
    power_mode_and_format_config_r[PMFC_WAKE_PM_HI:PMFC_WAKE_PM_LO];
  assign sleep_power_mode_sel =
    power_mode_and_format_config_r[PMFC_SLEEP_PM_HI:PMFC_SLEEP_PM_LO];
  assign output_byte_order_sel = power_mode_and_format_config_r[PMFC_ORDER_BIT];
  assign temperature_autoinc_incl = power_mode_and_format_config_r[PMFC_TEMP_BIT];
  assign msb_only_read_sel = power_mode_and_format_config_r[PMFC_FAST_BIT];

  // ****************************************
  // Power mode interpretation
  // ****************************************
  assign wake_mode = wake_power_mode_sel[1] ? PMFC_FLEX_PERF :
    wake_power_mode_sel[0] ? PMFC_HIGH_PERF :
    PMFC_LOW_POWER;
  assign sleep_mode = sleep_power_mode_sel[1] ? PMFC_FLEX_PERF :
    sleep_power_mode_sel[0] ? PMFC_HIGH_PERF : PMFC_LOW_POWER;

  // Upper nibble is a rate code unless wake is flexible
  assign wake_rate_code = wake_power_mode_sel[1] ? 4'h0 : rate_decimation_config[7:4];
  assign wake_decimation_code = wake_power_mode_sel[1] ? rate_decimation_config[7:4] :
    4'h0;
  assign sleep_rate_code = sleep_power_mode_sel[1] ? 4'h0 : rate_decimation_config[3:0];
  assign sleep_decimation_code = sleep_power_mode_sel[1] ? rate_decimation_config[3:0] :
    4'h0;

  assign active_mode = sleep_state ? sleep_mode : wake_mode;
  assign active_code = sleep_state ? rate_decimation_config[3:0] :
    rate_decimation_config[7:4];
  assign active_code_is_rate = (active_mode != PMFC_FLEX_PERF);
  // Idle time only matters in flexible mode
  assign active_idle_time = (active_mode != PMFC_FLEX_PERF) ? '0 :
    (sleep_state ? sleep_idle_time : wake_idle_time);

  // ****************************************
  // Output data formatting
  // ****************************************
  logic in_axis;
  logic in_mag;
  logic in_buf;
  logic is_sample;
  logic [7:0] sample_base;
  logic upper_addr;
  logic [7:0] sample_rel;

  assign in_axis = (reg_addr >= PMFC_AXIS_FIRST) && (reg_addr <= PMFC_AXIS_LAST);
  assign in_mag = (reg_addr >= PMFC_MAG_FIRST) && (reg_addr <= PMFC_MAG_LAST);
  assign in_buf = (reg_addr >= PMFC_BUF_FIRST) && (reg_addr <= PMFC_BUF_LAST);
  assign is_sample = in_axis | in_mag | in_buf;
  assign sample_base = in_axis ? PMFC_AXIS_FIRST : in_mag ? PMFC_MAG_FIRST : PMFC_BUF_FIRST;
  assign sample_rel = reg_addr - sample_base;
  assign upper_addr = sample_rel[0];

  logic [7:0] fmt_byte;

  pmfc_byte_mux #(
    .SAMPLE_W(SAMPLE_W)
  ) u_byte_mux (
    .clock(clock),
    .sys_rst(sys_rst),
    .sample(data_sample),
    .upper_addr(upper_addr),
    .formatted(is_sample),
    .big_endian(output_byte_order_sel),
    .fast_read(msb_only_read_sel),
    .byte_r(fmt_byte)
  );

  logic [7:0] plain_byte_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sample_data_r <= 1'b0;
      plain_byte_r <= 8'h00;
    end else begin
      sample_data_r <= is_sample;
      plain_byte_r <= data_rdata;
    end
  end

  // Non-sample fields stay little-endian, right-justified as supplied
  assign out_rdata = sample_data_r ? fmt_byte : plain_byte_r;

  // ****************************************
  // Burst address stepping
  // ****************************************
  logic [7:0] step_one;
  logic [7:0] step_two;
  logic skip_upper;
  logic fast_group;
  logic [7:0] burst_rel;

  assign fast_group = ((burst_addr >= PMFC_AXIS_FIRST) && (burst_addr <= PMFC_AXIS_LAST)) ||
    ((burst_addr >= PMFC_BUF_FIRST) && (burst_addr <= PMFC_BUF_LAST));
  assign burst_rel = burst_addr - ((burst_addr >= PMFC_BUF_FIRST) ? PMFC_BUF_FIRST :
    PMFC_AXIS_FIRST);
  assign skip_upper = burst_active && msb_only_read_sel && fast_group && !burst_rel[0];
  assign step_one = burst_addr + 8'h01;
  assign step_two = burst_addr + 8'h02;

  logic [7:0] stepped;
  assign stepped = skip_upper ? step_two : step_one;
  // Temperature skipped unless included
  assign burst_next_addr = (stepped == PMFC_TEMP_ADDR && !temperature_autoinc_incl) ?
    (stepped + 8'h01) : stepped;

  // ****************************************
  // Checks
  // ****************************************
  reg_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    (reg_wr && cfg_sel) |=> (power_mode_and_format_config_r == $past(reg_wdata)))
    else $error("config write not stored");
  reg_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    !(reg_wr && cfg_sel) |=> $stable(power_mode_and_format_config_r))
    else $error("config changed without write");
  wake_flex_a: assert property (@(posedge clock) disable iff (sys_rst)
    wake_power_mode_sel[1] |-> (wake_mode == PMFC_FLEX_PERF &&
      wake_decimation_code == rate_decimation_config[7:4]))
    else $error("wake flexible decode wrong");
  wake_rate_a: assert property (@(posedge clock) disable iff (sys_rst)
    (wake_power_mode_sel == 2'b00) |-> (wake_mode == PMFC_LOW_POWER &&
      wake_rate_code == rate_decimation_config[7:4]))
    else $error("wake low power decode wrong");
  wake_hpm_a: assert property (@(posedge clock) disable iff (sys_rst)
    (wake_power_mode_sel == 2'b01) |-> wake_mode == PMFC_HIGH_PERF)
    else $error("wake high performance decode wrong");
  sleep_mode_a: assert property (@(posedge clock) disable iff (sys_rst)
    !sleep_power_mode_sel[1] |-> (sleep_rate_code == rate_decimation_config[3:0]))
    else $error("sleep rate decode wrong");
  sleep_flex_a: assert property (@(posedge clock) disable iff (sys_rst)
    sleep_power_mode_sel[1] |-> (sleep_mode == PMFC_FLEX_PERF &&
      sleep_decimation_code == rate_decimation_config[3:0]))
    else $error("sleep flexible decode wrong");
  fast_read_a: assert property (@(posedge clock) disable iff (sys_rst)
    (is_sample && msb_only_read_sel) |=> out_rdata == $past(data_sample[SAMPLE_W-1 -: 8]))
    else $error("fast read byte wrong");
  little_end_a: assert property (@(posedge clock) disable iff (sys_rst)
    (is_sample && !msb_only_read_sel && !output_byte_order_sel && !upper_addr)
      |=> out_rdata == $past(data_sample[7:0]))
    else $error("little endian low byte wrong");
  big_end_a: assert property (@(posedge clock) disable iff (sys_rst)
    (is_sample && !msb_only_read_sel && output_byte_order_sel && !upper_addr)
      |=> out_rdata == $past(data_sample[SAMPLE_W-1 -: 8]))
    else $error("big endian high byte wrong");
  plain_data_a: assert property (@(posedge clock) disable iff (sys_rst)
    !is_sample |=> out_rdata == $past(data_rdata))
    else $error("plain field reformatted");
  burst_skip_a: assert property (@(posedge clock) disable iff (sys_rst)
    (skip_upper && burst_addr + 8'h02 != PMFC_TEMP_ADDR) |-> burst_next_addr == step_two)
    else $error("fast burst did not skip");
  temp_skip_a: assert property (@(posedge clock) disable iff (sys_rst)
    !temperature_autoinc_incl |-> burst_next_addr != PMFC_TEMP_ADDR)
    else $error("temperature not skipped");

  // ****************************************
  // Reset value and mode selection checks
  // ****************************************
  reset_value_a: assert property (@(posedge clock)
    sys_rst |=> power_mode_and_format_config_r == PMFC_CFG_RST)
    else $error("config not cleared by reset");
  wake_hpm_rate_a: assert property (@(posedge clock) disable iff (sys_rst)
    (wake_power_mode_sel == 2'b01) |-> wake_rate_code == rate_decimation_config[7:4])
    else $error("wake high performance rate wrong");
  sleep_lpm_a: assert property (@(posedge clock) disable iff (sys_rst)
    (sleep_power_mode_sel == 2'b00) |-> sleep_mode == PMFC_LOW_POWER)
    else $error("sleep low power decode wrong");
  sleep_hpm_a: assert property (@(posedge clock) disable iff (sys_rst)
    (sleep_power_mode_sel == 2'b01) |-> sleep_mode == PMFC_HIGH_PERF)
    else $error("sleep high performance decode wrong");
  wake_active_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!sleep_state && !wake_power_mode_sel[1]) |-> (active_code_is_rate &&
      active_code == rate_decimation_config[7:4] && active_idle_time == '0))
    else $error("wake rate selection wrong");
  wake_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!sleep_state && wake_power_mode_sel[1]) |-> (!active_code_is_rate &&
      active_code == rate_decimation_config[7:4] && active_idle_time == wake_idle_time))
    else $error("wake flexible selection wrong");
  sleep_active_a: assert property (@(posedge clock) disable iff (sys_rst)
    (sleep_state && !sleep_power_mode_sel[1]) |-> (active_code_is_rate &&
      active_code == rate_decimation_config[3:0] && active_idle_time == '0))
    else $error("sleep rate selection wrong");
  sleep_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
    (sleep_state && sleep_power_mode_sel[1]) |-> (!active_code_is_rate &&
      active_code == rate_decimation_config[3:0] && active_idle_time == sleep_idle_time))
    else $error("sleep flexible selection wrong");

  // ****************************************
  // Upper byte format checks
  // ****************************************
  little_upper_a: assert property (@(posedge clock) disable iff (sys_rst)
    (is_sample && !msb_only_read_sel && !output_byte_order_sel && upper_addr)
      |=> out_rdata == {{(16 - SAMPLE_W){1'b0}}, $past(data_sample[SAMPLE_W-1:8])})
    else $error("little endian high byte wrong");
  big_upper_a: assert property (@(posedge clock) disable iff (sys_rst)
    (is_sample && !msb_only_read_sel && output_byte_order_sel && upper_addr)
      |=> out_rdata == {$past(data_sample[SAMPLE_W-9:0]), {(16 - SAMPLE_W){1'b0}}})
    else $error("big endian low byte wrong");

  // ****************************************
  // Pointer stepping checks
  // ****************************************
  temp_incl_a: assert property (@(posedge clock) disable iff (sys_rst)
    (temperature_autoinc_incl && burst_addr + 8'h01 == PMFC_TEMP_ADDR)
      |-> burst_next_addr == PMFC_TEMP_ADDR)
    else $error("temperature not included");
  mag_step_a: assert property (@(posedge clock) disable iff (sys_rst)
    (burst_addr >= PMFC_MAG_FIRST && burst_addr <= PMFC_MAG_LAST)
      |-> burst_next_addr == burst_addr + 8'h01)
    else $error("magnitude pointer skipped");
  burst_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!burst_active && burst_addr + 8'h01 != PMFC_TEMP_ADDR)
      |-> burst_next_addr == burst_addr + 8'h01)
    else $error("pointer skipped outside burst");
endmodule // pmfc_config

//--- hw/pmfc_pkg.sv
// Purpose: Constants for the power mode and output format configuration block
// Assumes: 8-bit register bank reached over the device's internal register port
// Notes: Offsets are byte addresses of the device register map
package pmfc_pkg;
  localparam logic [7:0] PMFC_CFG_ADDR = 8'h16;
  localparam logic [7:0] PMFC_RATE_ADDR = 8'h17;
  localparam logic [7:0] PMFC_CFG_RST = 8'h00;
  localparam logic [7:0] PMFC_RATE_RST = 8'h00;
  localparam int PMFC_WAKE_PM_HI = 7;
  localparam int PMFC_WAKE_PM_LO = 6;
  localparam int PMFC_SLEEP_PM_HI = 5;
  localparam int PMFC_SLEEP_PM_LO = 4;
  localparam int PMFC_ORDER_BIT = 3;
  localparam int PMFC_RSVD_BIT = 2;
  localparam int PMFC_TEMP_BIT = 1;
  localparam int PMFC_FAST_BIT = 0;
  localparam int PMFC_SAMPLE_W = 12;
  // Output data addresses: axis results, magnitude, buffer, temperature
  localparam logic [7:0] PMFC_TEMP_ADDR = 8'h01;
  localparam logic [7:0] PMFC_AXIS_FIRST = 8'h04;
  localparam logic [7:0] PMFC_AXIS_LAST = 8'h09;
  localparam logic [7:0] PMFC_MAG_FIRST = 8'h0a;
  localparam logic [7:0] PMFC_MAG_LAST = 8'h0b;
  localparam logic [7:0] PMFC_BUF_FIRST = 8'h0c;
  localparam logic [7:0] PMFC_BUF_LAST = 8'h11;
  typedef enum logic [1:0] {
    PMFC_LOW_POWER = 2'b00,
    PMFC_HIGH_PERF = 2'b01,
    PMFC_FLEX_PERF = 2'b10
  } pmfc_mode_type;
endpackage

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the power mode and output format register
// Assumes: Default parameters, 12-bit samples, reads one cycle after address
// Notes: Drivers queue expected values; a watcher compares at the falling edge
`timescale 1ns/10ps
module tb_top
  import pmfc_pkg::*;
;
  typedef struct {int sel; int due; logic [41:0] exp;} pmfc_note_type;
  logic clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, sleep_state = 0, burst_active = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, rate_decimation_config = 0, data_rdata = 0;
  logic [7:0] burst_addr = 0, cfg_m = 8'h00;
  logic [11:0] wake_idle_time = 0, sleep_idle_time = 0, data_sample = 0;
  logic [7:0] reg_rdata, burst_next_addr, out_rdata;
  logic reg_hit, active_code_is_rate, output_byte_order_sel, temperature_autoinc_incl;
  logic msb_only_read_sel;
  pmfc_mode_type wake_mode, sleep_mode, active_mode;
  logic [3:0] wake_rate_code, wake_decimation_code, sleep_rate_code, sleep_decimation_code;
  logic [3:0] active_code;
  logic [11:0] active_idle_time;
  int cyc = 0, fail_count = 0, num_checks = 0;
  pmfc_note_type q[$];
  pmfc_config i_dut (.clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .rate_decimation_config(rate_decimation_config), .wake_idle_time(wake_idle_time),
    .sleep_idle_time(sleep_idle_time), .sleep_state(sleep_state), .data_sample(data_sample),
    .data_rdata(data_rdata), .burst_active(burst_active), .burst_addr(burst_addr),
    .burst_next_addr(burst_next_addr), .out_rdata(out_rdata), .wake_mode(wake_mode),
    .sleep_mode(sleep_mode), .active_mode(active_mode), .wake_rate_code(wake_rate_code),
    .wake_decimation_code(wake_decimation_code), .sleep_rate_code(sleep_rate_code),
    .sleep_decimation_code(sleep_decimation_code), .active_code(active_code),
    .active_code_is_rate(active_code_is_rate), .active_idle_time(active_idle_time),
    .output_byte_order_sel(output_byte_order_sel),
    .temperature_autoinc_incl(temperature_autoinc_incl), .msb_only_read_sel(msb_only_read_sel));
  always #4 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  // ****************************************
  // Expected values
  // ****************************************
  function automatic logic [41:0] dec_exp(logic [7:0] c, logic [7:0] r, logic s);
    logic [1:0] wm, sm, am;
    wm = c[7] ? 2'b10 : {1'b0, c[6]};
    sm = c[5] ? 2'b10 : {1'b0, c[4]};
    am = s ? sm : wm;
    return {wm, sm, am, wm[1] ? 4'h0 : r[7:4], wm[1] ? r[7:4] : 4'h0, sm[1] ? 4'h0 : r[3:0],
      sm[1] ? r[3:0] : 4'h0, s ? r[3:0] : r[7:4], !am[1],
      am[1] ? (s ? sleep_idle_time : wake_idle_time) : 12'h000, c[3], c[1], c[0]};
  endfunction
  function automatic logic [7:0] fmt_exp(logic [7:0] a, logic [11:0] s, logic [7:0] c);
    if (a < 8'h04 || a > 8'h11) return data_rdata;
    if (c[0]) return s[11:4];
    if (c[3]) return a[0] ? {s[3:0], 4'h0} : s[11:4];
    return a[0] ? {4'h0, s[11:8]} : s[7:0];
  endfunction
  function automatic logic [7:0] next_exp(logic [7:0] a, logic [7:0] c);
    logic [7:0] n;
    n = a + 8'h01;
    if (burst_active && c[0] && !a[0] &&
      ((a >= 8'h04 && a <= 8'h09) || (a >= 8'h0c && a <= 8'h11))) n = a + 8'h02;
    if (n == 8'h01 && !c[1]) n = 8'h02;
    return n;
  endfunction
  // ****************************************
  // Compare and watch
  // ****************************************
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_dec(input logic [41:0] e, input logic [41:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic note(input int sel, input logic [41:0] e);
    q.push_back('{sel, cyc, e});
  endtask
  always @(negedge clock) begin
    pmfc_note_type n;
    while (q.size() > 0 && q[0].due <= cyc) begin
      n = q.pop_front();
      case (n.sel)
        0: cmp_byte(n.exp[7:0], reg_rdata);
        1: cmp_byte(n.exp[7:0], out_rdata);
        2: cmp_byte(n.exp[7:0], burst_next_addr);
        3: cmp_byte(n.exp[7:0], {7'h00, reg_hit});
        default: cmp_dec(n.exp, {wake_mode, sleep_mode, active_mode, wake_rate_code,
          wake_decimation_code, sleep_rate_code, sleep_decimation_code, active_code,
          active_code_is_rate, active_idle_time, output_byte_order_sel,
          temperature_autoinc_incl, msb_only_read_sel});
      endcase
    end
  end
  // ****************************************
  // Drivers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    rate_decimation_config = $urandom;
    wake_idle_time = $urandom;
    sleep_idle_time = $urandom;
    note(3, {41'h0, a == PMFC_CFG_ADDR});
    if (a == PMFC_CFG_ADDR) cfg_m = d;
    @(posedge clock);
    #1;
    reg_wr = 0;
    note(0, {34'h0, cfg_m});
    note(4, dec_exp(cfg_m, rate_decimation_config, sleep_state));
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    @(posedge clock);
    #1;
    reg_addr = a;
    data_sample = $urandom;
    data_rdata = $urandom;
    reg_rd = 1;
    e = fmt_exp(a, data_sample, cfg_m);
    note(3, {41'h0, a == PMFC_CFG_ADDR});
    @(posedge clock);
    #1;
    reg_rd = 0;
    note(1, {34'h0, e});
  endtask
  task automatic burst(input logic [7:0] a);
    @(posedge clock);
    #1;
    burst_addr = a;
    burst_active = $urandom;
    note(2, {34'h0, next_exp(a, cfg_m)});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clock) begin
    if (cyc == 3000) begin
      fail_count++;
      conclude();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] c;
    void'($urandom(32'he2364b03));
    repeat (8) @(posedge clock);
    #1;
    sys_rst = 0;
    note(0, {34'h0, PMFC_CFG_RST});
    note(4, dec_exp(8'h00, rate_decimation_config, sleep_state));
    for (int i = 0; i < 32; i++) begin
      @(posedge clock);
      #1;
      sleep_state = i[4];
      c = $urandom;
      wr(PMFC_CFG_ADDR, {i[3:0], c[3], 1'b0, c[1:0]});
    end
    wr(8'h17, 8'hff);
    wr(8'h15, 8'hff);
    for (int m = 0; m < 4; m++) begin
      wr(PMFC_CFG_ADDR, {4'h5, m[1], 1'b0, m[1] ^ m[0], m[0]});
      for (int a = 0; a < 20; a++) rd(a[7:0]);
      rd(PMFC_CFG_ADDR);
      for (int a = 0; a < 20; a++) burst(a[7:0]);
      burst(8'hff);
    end
    repeat (3) @(posedge clock);
    conclude();
  end
endmodule // tb_top
